// [rtl/fpr_consts.vh]
// Constants for the flash programming address and data register block
`ifndef FPR_CONSTS_VH
`define FPR_CONSTS_VH

// ==========================================================
// Register byte offsets
`define FPR_OFS_CTRL      8'h00
`define FPR_OFS_KEY       8'h10
`define FPR_OFS_ADDR      8'h20
`define FPR_OFS_DATA_LOW  8'h30
`define FPR_OFS_DATA_HIGH 8'h40
`define FPR_OFS_SRC       8'h50

// ==========================================================
// Control register field positions
`define FPR_CTRL_START    15
`define FPR_CTRL_WREN     14
`define FPR_CTRL_WRERR    13
`define FPR_CTRL_LVDERR   12
`define FPR_CTRL_OP_HI    3
`define FPR_CTRL_OP_LO    0

// ==========================================================
// Operation select codes
`define FPR_OP_NOP        4'h0
`define FPR_OP_DWORD      4'h2
`define FPR_OP_ROW        4'h3
`define FPR_OP_PAGE       4'h4

// ==========================================================
// Address masks: cleared bits are ignored by the operation
`define FPR_MASK_PAGE     32'hFFFFF800
`define FPR_MASK_ROW      32'hFFFFFF00
`define FPR_MASK_DWORD    32'hFFFFFFFC

// ==========================================================
// Reset values and unlock keys (key values are arbitrary)
`define FPR_RST_WORD      32'h00000000
`define FPR_KEY_FIRST     32'h5A5A0F0F
`define FPR_KEY_SECOND    32'hA5A5F0F0

// ==========================================================
// Bus encodings
`define FPR_HSIZE_WORD    3'h2
`define FPR_HRESP_OKAY    1'h0

`endif

// [rtl/fpr_unlock.v]
// Unlock key sequence tracker for the flash programming block
`timescale 1ns/1ps
`include "fpr_consts.vh"

module fpr_unlock (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        key_write,
  input  wire [31:0] key_data,
  input  wire        other_write,
  output reg         unlocked_reg
);

  reg got_first_reg;

  // ==========================================================
  // Two keys in back-to-back writes arm the start bit once
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      got_first_reg <= 1'b0;
      unlocked_reg  <= 1'b0;
    end else if (key_write) begin
      got_first_reg <= (key_data == `FPR_KEY_FIRST);
      unlocked_reg  <= got_first_reg && (key_data == `FPR_KEY_SECOND);
    end else if (other_write) begin
      // Any other register write ends the sequence or consumes it
      got_first_reg <= 1'b0;
      unlocked_reg  <= 1'b0;
    end
  end

endmodule

// [rtl/fpr_op_decode.v]
// Operation decode and target address interpretation
`timescale 1ns/1ps
`include "fpr_consts.vh"

module fpr_op_decode (
  input  wire [3:0]  op,
  input  wire [31:0] target_addr,
  output reg  [31:0] eff_addr,
  output reg         op_known
);

  // Clears the ignored low address bits
  function [31:0] mask_addr;
    input [31:0] a;
    input [31:0] m;
    begin
      mask_addr = a & m;
    end
  endfunction

  // ==========================================================
  // Address seen by the flash array for each operation
  always @* begin
    eff_addr = target_addr;
    op_known = 1'b1;
    case (op)
      `FPR_OP_PAGE:  eff_addr = mask_addr(target_addr, `FPR_MASK_PAGE);
      `FPR_OP_ROW:   eff_addr = mask_addr(target_addr, `FPR_MASK_ROW);
      `FPR_OP_DWORD: eff_addr = mask_addr(target_addr, `FPR_MASK_DWORD);
      `FPR_OP_NOP:   eff_addr = target_addr;
      default:       op_known = 1'b0;
    endcase
  end

endmodule

// [rtl/fpr_top.v]
// Flash programming address, data, source address and unlock key registers
`timescale 1ns/1ps
`include "fpr_consts.vh"

module fpr_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  output reg         flash_req,
  output reg  [3:0]  flash_op,
  output reg  [31:0] flash_addr,
  output reg  [63:0] flash_wdata,
  output reg  [31:0] flash_src_addr,
  input  wire        flash_done,
  input  wire        flash_fail,
  input  wire        low_voltage,
  output reg         busy
);

  // ==========================================================
  // Sequencer states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_WAIT = 2'b01;
  localparam [1:0] ST_DONE = 2'b10;

  // Bus slave pipeline state
  reg  [7:0]  addr_reg;
  reg         wr_pend_reg;
  reg         rd_pend_reg;

  // Programming registers seen by software
  reg  [31:0] target_addr_reg;
  reg  [31:0] data_low_reg;
  reg  [31:0] data_high_reg;
  reg  [31:0] src_addr_reg;

  // Control register fields
  reg  [3:0]  op_reg;
  reg         wren_reg;
  reg         wrerr_reg;
  reg         lvderr_reg;

  // Operation sequencer
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;

  // Low voltage synchroniser flops
  reg         lv_meta_reg;
  reg         lv_sync_reg;

  // Combinational helpers
  reg  [31:0] rd_word;
  reg         wrerr_next;
  reg         lvderr_next;

  // Bus strobes
  wire        bus_take;
  wire        wr_ctrl;
  wire        wr_key;
  wire        wr_other;

  // Start qualification
  wire        unlocked;
  wire        start_go;

  // Decoded operation
  wire [31:0] eff_addr;
  wire        op_known;

  // ==========================================================
  // Offset decode shared by the write strobes
  function reg_hit;
    input [7:0] ofs_seen;
    input [7:0] ofs_want;
    begin
      reg_hit = (ofs_seen == ofs_want);
    end
  endfunction

  // ==========================================================
  // Bus slave: address phase capture and strobes
  assign bus_take = hsel && htrans[1] && hready;
  assign wr_ctrl  = wr_pend_reg && reg_hit(addr_reg, `FPR_OFS_CTRL);
  assign wr_key   = wr_pend_reg && reg_hit(addr_reg, `FPR_OFS_KEY);
  assign wr_other = wr_pend_reg && !wr_key;

  // Start is honoured only with write enable set, unlocked and idle
  // A start while busy is dropped, not queued
  assign start_go = wr_ctrl && hwdata[`FPR_CTRL_START] && wren_reg && unlocked
                    && (state_reg == ST_IDLE);

  // Writes finish with no wait; reads take one wait state so read data
  // come from a flop and always see the result of a preceding write
  // Writes of any size but a word leave every register untouched
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg    <= 8'h00;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hreadyout   <= 1'b1;
      hrdata      <= `FPR_RST_WORD;
      hresp       <= `FPR_HRESP_OKAY;
    end else if (bus_take) begin
      addr_reg    <= haddr[7:0];
      wr_pend_reg <= hwrite && (hsize == `FPR_HSIZE_WORD);
      rd_pend_reg <= !hwrite;
      hreadyout   <= hwrite;
    end else begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hreadyout   <= 1'b1;
      if (rd_pend_reg) begin
        hrdata <= rd_word;
      end
    end
  end

  // ==========================================================
  // Read multiplexer; unmapped offsets read as zero
  // The key register never returns what was written to it
  always @* begin
    rd_word = `FPR_RST_WORD;
    case (addr_reg)
      `FPR_OFS_CTRL: begin
        rd_word[`FPR_CTRL_START]  = busy;
        rd_word[`FPR_CTRL_WREN]   = wren_reg;
        rd_word[`FPR_CTRL_WRERR]  = wrerr_reg;
        rd_word[`FPR_CTRL_LVDERR] = lvderr_reg;
        rd_word[`FPR_CTRL_OP_HI:`FPR_CTRL_OP_LO] = op_reg;
      end
      `FPR_OFS_KEY:       rd_word = `FPR_RST_WORD;
      `FPR_OFS_ADDR:      rd_word = target_addr_reg;
      `FPR_OFS_DATA_LOW:  rd_word = data_low_reg;
      `FPR_OFS_DATA_HIGH: rd_word = data_high_reg;
      `FPR_OFS_SRC:       rd_word = src_addr_reg;
      default:            rd_word = `FPR_RST_WORD;
    endcase
  end

  // ==========================================================
  // Address, data and source address registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target_addr_reg <= `FPR_RST_WORD;
      data_low_reg    <= `FPR_RST_WORD;
      data_high_reg   <= `FPR_RST_WORD;
      src_addr_reg    <= `FPR_RST_WORD;
    end else if (wr_pend_reg) begin
      case (addr_reg)
        `FPR_OFS_ADDR:      target_addr_reg <= hwdata;
        `FPR_OFS_DATA_LOW:  data_low_reg    <= hwdata;
        `FPR_OFS_DATA_HIGH: data_high_reg   <= hwdata;
        `FPR_OFS_SRC:       src_addr_reg    <= hwdata;
        default:            src_addr_reg    <= src_addr_reg;
      endcase
    end
  end

  // ==========================================================
  // Control fields: operation select is locked while write enable is set
  // Write enable itself is taken from every control write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_reg   <= `FPR_OP_NOP;
      wren_reg <= 1'b0;
    end else if (wr_ctrl) begin
      wren_reg <= hwdata[`FPR_CTRL_WREN];
      if (!wren_reg) begin
        op_reg <= hwdata[`FPR_CTRL_OP_HI:`FPR_CTRL_OP_LO];
      end
    end
  end

  // ==========================================================
  // Unlock key tracking; the key itself is never stored
  // A start attempt without a fresh unlock is ignored
  fpr_unlock u_unlock (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .key_write    (wr_key),
    .key_data     (hwdata),
    .other_write  (wr_other),
    .unlocked_reg (unlocked)
  );

  // ==========================================================
  // Operation decode and address interpretation
  fpr_op_decode u_decode (
    .op          (op_reg),
    .target_addr (target_addr_reg),
    .eff_addr    (eff_addr),
    .op_known    (op_known)
  );

  // ==========================================================
  // Low voltage pin synchroniser
  // Only the second flop is read by the sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lv_meta_reg <= 1'b0;
      lv_sync_reg <= 1'b0;
    end else begin
      lv_meta_reg <= low_voltage;
      lv_sync_reg <= lv_meta_reg;
    end
  end

  // ==========================================================
  // Sequencer next state
  // Reserved codes and no operation skip the wait for the engine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_go) begin
          if ((op_reg != `FPR_OP_NOP) && op_known) begin
            state_next = ST_WAIT;
          end else begin
            state_next = ST_DONE;
          end
        end
      end
      ST_WAIT: begin
        if (flash_done) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Error flags: a hardware set wins over the clear by no operation
  // Both flags keep their value until a no operation start
  always @* begin
    wrerr_next  = wrerr_reg;
    lvderr_next = lvderr_reg;
    if (start_go && (op_reg == `FPR_OP_NOP)) begin
      wrerr_next  = 1'b0;
      lvderr_next = 1'b0;
    end
    if (start_go && !op_known) begin
      wrerr_next = 1'b1;
    end
    if ((state_reg == ST_WAIT) && flash_done && flash_fail) begin
      wrerr_next = 1'b1;
    end
    if ((state_reg == ST_WAIT) && lv_sync_reg) begin
      lvderr_next = 1'b1;
    end
  end

  // ==========================================================
  // Sequencer registers and flash command outputs
  // Busy drops one edge after the done state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg      <= ST_IDLE;
      busy           <= 1'b0;
      wrerr_reg      <= 1'b0;
      lvderr_reg     <= 1'b0;
      flash_req      <= 1'b0;
      flash_op       <= `FPR_OP_NOP;
      flash_addr     <= `FPR_RST_WORD;
      flash_wdata    <= {`FPR_RST_WORD, `FPR_RST_WORD};
      flash_src_addr <= `FPR_RST_WORD;
    end else begin
      state_reg  <= state_next;
      wrerr_reg  <= wrerr_next;
      lvderr_reg <= lvderr_next;
      flash_req  <= 1'b0;
      if (start_go) begin
        busy <= 1'b1;
      end else if (state_reg == ST_DONE) begin
        busy <= 1'b0;
      end
      if (start_go && (state_next == ST_WAIT)) begin
        // Snapshot the command so the flash engine sees stable values
        flash_req      <= 1'b1;
        flash_op       <= op_reg;
        flash_addr     <= eff_addr;
        flash_wdata    <= {data_high_reg, data_low_reg};
        flash_src_addr <= src_addr_reg;
      end
    end
  end

endmodule

// [verif/fpr_top_props.sv]
// Port assertions for the flash programming register block
`timescale 1ns/1ps
module fpr_top_props (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire [31:0] hrdata,
  input wire        hresp,
  input wire        flash_req,
  input wire [3:0]  flash_op,
  input wire [31:0] flash_addr,
  input wire [63:0] flash_wdata,
  input wire [31:0] flash_src_addr,
  input wire        flash_done,
  input wire        flash_fail,
  input wire        low_voltage,
  input wire        busy
);
  // ==========================================================
  // Read request seen on the bus
  wire rd_take = hsel && htrans[1] && hready && !hwrite;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // Bus and command checks
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_key_zero: assert property (rd_take && haddr[7:0] == 8'h10 |-> ##2 hrdata == 32'h0)
    else $error("key register read not zero");
  a_req_pulse: assert property (flash_req |=> !flash_req)
    else $error("command pulse too long");
  a_req_busy: assert property (flash_req |-> busy && !$past(busy))
    else $error("busy not raised with command");
  a_op_known: assert property (flash_req |-> flash_op inside {4'h2, 4'h3, 4'h4})
    else $error("command with bad operation");
  a_page_mask: assert property (flash_req && flash_op == 4'h4 |-> flash_addr[10:0] == 11'h0)
    else $error("page address low bits kept");
  a_row_mask: assert property (flash_req && flash_op == 4'h3 |-> flash_addr[7:0] == 8'h0)
    else $error("row address low bits kept");
  a_dword_mask: assert property (flash_req && flash_op == 4'h2 |-> flash_addr[1:0] == 2'h0)
    else $error("double-word address low bits kept");
  a_done_idle: assert property (busy && flash_done |-> ##2 !busy)
    else $error("busy not cleared after done");
  c_page: cover property (flash_req && flash_op == 4'h4);
  c_row: cover property (flash_req && flash_op == 4'h3);
  c_dword: cover property (flash_req && flash_op == 4'h2);
endmodule

bind fpr_top fpr_top_props fpr_top_props_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .flash_req(flash_req), .flash_op(flash_op), .flash_addr(flash_addr),
  .flash_wdata(flash_wdata), .flash_src_addr(flash_src_addr), .flash_done(flash_done),
  .flash_fail(flash_fail), .low_voltage(low_voltage), .busy(busy));

// [verif/fpr_top_tb.sv]
// Self-checking bench for the flash programming register block
`timescale 1ns/1ps
`include "fpr_consts.vh"
module fpr_top_tb;
  reg         hclk;
  reg         hresetn;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  reg  [2:0]  hsize;
  reg         flash_done;
  reg         flash_fail;
  reg         low_voltage;
  reg  [31:0] rd;
  wire        hreadyout;
  wire [31:0] hrdata;
  wire        hresp;
  wire        flash_req;
  wire [3:0]  flash_op;
  wire [31:0] flash_addr;
  wire [63:0] flash_wdata;
  wire [31:0] flash_src_addr;
  wire        busy;
  integer     failures = 0;
  integer     checked = 0;
  integer     cycles = 0;
  integer     reqs = 0;
  integer     i;

  fpr_top fpr_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .flash_req(flash_req), .flash_op(flash_op), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_src_addr(flash_src_addr), .flash_done(flash_done),
    .flash_fail(flash_fail), .low_voltage(low_voltage), .busy(busy));

  // Clock generation
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Timeout and command pulse counting
  always @(posedge hclk) begin
    cycles = cycles + 1;
    if (flash_req === 1'b1)
      reqs = reqs + 1;
    if (cycles == 2000) begin
      failures = failures + 1;
      final_report;
    end
  end

  // ==========================================================
  // Helpers
  function [31:0] pat(input integer k);
    pat = 32'h1D0127FF ^ (k * 32'h11111111);
  endfunction

  task check(input [63:0] seen, input [63:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Single transfer at the hsize already driven; read data lands in rd
  task bus(input wr, input [31:0] a, input [31:0] d);
    begin
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask

  // Arm an operation, optionally unlock, start it and check the command
  task run_op(input [3:0] op, input [31:0] m, input want, input unl);
    integer n;
    begin
      n = reqs;
      bus(1'b1, `FPR_OFS_CTRL, 32'h0);
      bus(1'b1, `FPR_OFS_CTRL, 32'h00004000 | op);
      if (unl) begin
        bus(1'b1, `FPR_OFS_KEY, `FPR_KEY_FIRST);
        bus(1'b1, `FPR_OFS_KEY, `FPR_KEY_SECOND);
      end
      bus(1'b1, `FPR_OFS_CTRL, 32'h0000C000);
      repeat (4) @(posedge hclk);
      check(reqs - n, want);
      if (want) begin
        check(flash_op, op);
        check(flash_addr, pat(0) & m);
        check(flash_wdata, {pat(2), pat(1)});
        check(flash_src_addr, pat(3));
        flash_done <= 1'b1;
        @(posedge hclk);
        flash_done <= 1'b0;
      end
      repeat (3) @(posedge hclk);
      check(busy, 1'b0);
      $display("test op %h done", op);
    end
  endtask

  task final_report;
    begin
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    flash_done = 1'b0;
    hsize = `FPR_HSIZE_WORD;
    flash_fail = 1'b0;
    low_voltage = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 5; i = i + 1) begin
      bus(1'b0, 32'h10 + 16 * i, 32'h0);
      check(rd, 32'h0);
    end
    $display("test reset values done");
    for (i = 0; i < 4; i = i + 1)
      bus(1'b1, 32'h20 + 16 * i, pat(i));
    for (i = 0; i < 4; i = i + 1) begin
      bus(1'b0, 32'h20 + 16 * i, 32'h0);
      check(rd, pat(i));
    end
    bus(1'b1, `FPR_OFS_KEY, 32'hFFFFFFFF);
    bus(1'b0, `FPR_OFS_KEY, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 32'h60, 32'hFFFFFFFF);
    bus(1'b0, 32'h60, 32'h0);
    check(rd, 32'h0);
    hsize <= 3'h0;
    bus(1'b1, `FPR_OFS_ADDR, 32'hFFFFFFFF);
    hsize <= `FPR_HSIZE_WORD;
    bus(1'b0, `FPR_OFS_ADDR, 32'h0);
    check(rd, pat(0));
    $display("test register access done");
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 4; i = i + 1) begin
      bus(1'b0, 32'h20 + 16 * i, 32'h0);
      check(rd, 32'h0);
    end
    for (i = 0; i < 4; i = i + 1)
      bus(1'b1, 32'h20 + 16 * i, pat(i));
    $display("test mid-run reset done");
    run_op(`FPR_OP_PAGE, `FPR_MASK_PAGE, 1'b1, 1'b1);
    flash_fail <= 1'b1;
    low_voltage <= 1'b1;
    run_op(`FPR_OP_ROW, `FPR_MASK_ROW, 1'b1, 1'b1);
    flash_fail <= 1'b0;
    low_voltage <= 1'b0;
    bus(1'b0, `FPR_OFS_CTRL, 32'h0);
    check(rd, 32'h00007003);
    run_op(`FPR_OP_DWORD, `FPR_MASK_DWORD, 1'b1, 1'b1);
    run_op(`FPR_OP_NOP, 32'h0, 1'b0, 1'b1);
    bus(1'b0, `FPR_OFS_CTRL, 32'h0);
    check(rd, 32'h00004000);
    run_op(4'h7, 32'h0, 1'b0, 1'b1);
    bus(1'b0, `FPR_OFS_CTRL, 32'h0);
    check(rd, 32'h00006007);
    run_op(`FPR_OP_DWORD, `FPR_MASK_DWORD, 1'b0, 1'b0);
    final_report;
  end
endmodule
